// [core/irc_cfg.svh]
// offsets, field positions, reset values and timing counts of the interrupt request block
`ifndef IRC_CFG_SVH
`define IRC_CFG_SVH
`define IRC_OFF_ENABLE 8'h00
`define IRC_OFF_PRIORITY 8'h04
`define IRC_OFF_TCTRL 8'h08
`define IRC_OFF_UCTRL 8'h0c
`define IRC_OFF_PCTRL 8'h10
`define IRC_OFF_STATUS 8'h14
`define IRC_EN_GLOBAL 7
`define IRC_EN_EXT0 0
`define IRC_EN_TMR0 1
`define IRC_EN_EXT1 2
`define IRC_EN_TMR1 3
`define IRC_EN_UART 4
`define IRC_TC_EDGE0 0
`define IRC_TC_FLAG0 1
`define IRC_TC_EDGE1 2
`define IRC_TC_FLAG1 3
`define IRC_TC_TRUN0 4
`define IRC_TC_OVF0 5
`define IRC_TC_TRUN1 6
`define IRC_TC_OVF1 7
`define IRC_UC_RX 0
`define IRC_UC_TX 1
`define IRC_UC_REN 4
`define IRC_PC_PWEN 3
`define IRC_PC_PWFLAG 5
`define IRC_RST_BYTE 8'h00
`define IRC_VEC_BASE 16'h0003
`define IRC_VEC_STEP 16'h0008
`define IRC_ACK_CYCLES 3'h4
`endif

// [core/irc_pkg.sv]
// types of the interrupt request block
package irc_pkg;
  typedef enum logic [2:0] {
    IRC_IDLE = 3'b000,
    IRC_IA1 = 3'b001,
    IRC_IA2 = 3'b010,
    IRC_IA3 = 3'b011,
    IRC_IA4 = 3'b100
  } irc_state_t;
  // source index doubles as vector slot number
  typedef enum logic [2:0] {
    IRC_SRC_EXT0 = 3'b000,
    IRC_SRC_TMR0 = 3'b001,
    IRC_SRC_EXT1 = 3'b010,
    IRC_SRC_TMR1 = 3'b011,
    IRC_SRC_UART = 3'b100,
    IRC_SRC_PWR = 3'b101
  } irc_src_t;
  typedef struct packed {
    irc_state_t st;
    logic [7:0] ien;
    logic [7:0] ipr;
    logic [7:0] tctrl;
    logic [7:0] uctrl;
    logic [7:0] pctrl;
    logic [1:0] pin_m;
    logic [1:0] pin_s;
    logic [1:0] pin_d;
    logic [5:0] latched;
    logic [2:0] src;
    logic hi_sel;
    logic [1:0] active;
    logic one_more;
    logic irq_req;
    logic [15:0] vec;
    logic awdone;
    logic wdone;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] bresp;
    logic awready;
    logic wready;
    logic [3:0] wstrb;
  } irc_regs_t;
endpackage

// [core/irc_top.sv]
// interrupt request control with an axi4-lite register slave
`timescale 1ns/1ns
`include "irc_cfg.svh"
// What this block does
// - six vectors from 0003h, eight bytes apart; service calls the chosen vector
// - request raised only when the core signals an instruction boundary
// - return from service clears the in-service level and resumes
// - timer, serial and power event flags set even when their source is disabled
// - flag of serviced source cleared on vector call, serial and level-mode external flags excepted
// - global enable bit 7 gates all sources but power warning
// - reset clears global enable
// - per-source enables in enable register bits 0-4, power warning in power bit 3
// - external pins act as interrupts only while individually enabled
// - external pins sampled once per machine cycle
// - external flags at timer control bits 1 and 3
// - timer control bits 0 and 2 select level (0) or falling edge (1)
// - level mode flag follows low pin without latching
// - level still low after return: one instruction runs before retaking
// - edge mode latches the falling edge until serviced
// - falling edges on either pin ignored while any service routine is in progress
// - timer overflows set timer control bits 5 and 7
// - serial rx and tx flags share one vector, at serial bits 0 and 1
// - reset stops timers and disables serial reception
// - equal priority order: power, ext0, timer0, ext1, timer1, serial
// - low preempted only by high; high not by high; power preempts all
// - power warning flag clears on software read, stays set while supply low
// - acknowledge passes four states after the latch: resolve, raise, wait for ack, finish
module irc_top import irc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic rx_done,
  input wire logic tx_done,
  input wire logic power_low,
  input wire logic insn_boundary,
  input wire logic irq_ack,
  input wire logic return_from_irq,
  output logic irq_request,
  output logic [15:0] irq_vector,
  output logic [7:0] port3_irq_pins,
  output logic timer0_run,
  output logic timer1_run,
  output logic uart_rx_enable
);
  irc_regs_t r_r, r_nxt;
  logic [5:0] pend;
  logic [5:0] hi;
  logic aw_go, w_go, rd_go;
  logic [7:0] rd_addr;

  function automatic logic [2:0] pick(input logic [5:0] req);
    logic [2:0] p;
    p = 3'h7;
    if (req[IRC_SRC_PWR]) p = IRC_SRC_PWR;
    else if (req[IRC_SRC_EXT0]) p = IRC_SRC_EXT0;
    else if (req[IRC_SRC_TMR0]) p = IRC_SRC_TMR0;
    else if (req[IRC_SRC_EXT1]) p = IRC_SRC_EXT1;
    else if (req[IRC_SRC_TMR1]) p = IRC_SRC_TMR1;
    else if (req[IRC_SRC_UART]) p = IRC_SRC_UART;
    return p;
  endfunction

  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    return s[0] ? d[7:0] : old;
  endfunction

  assign aw_go = s_axi_awvalid & r_r.awready;
  assign w_go = s_axi_wvalid & r_r.wready;
  assign rd_go = s_axi_arvalid & r_r.arready;
  assign rd_addr = s_axi_araddr;

  always_comb begin
    logic [7:0] wa;
    logic [2:0] s;
    logic [5:0] clr;
    logic blocked;
    wa = 8'h00;
    s = 3'h0;
    clr = 6'h00;
    blocked = 1'b0;
    r_nxt = r_r;
    pend = 6'h00;
    hi = 6'h00;
    // bus write channels taken independently
    if (aw_go) begin
      r_nxt.awdone = 1'b1;
      r_nxt.waddr = s_axi_awaddr;
    end
    if (w_go) begin
      r_nxt.wdone = 1'b1;
      r_nxt.wdata = s_axi_wdata;
      r_nxt.wstrb = s_axi_wstrb;
    end
    // pins pass two flops before use; sampled every machine cycle
    r_nxt.pin_m = {ext_irq1_pin, ext_irq0_pin};
    r_nxt.pin_s = r_r.pin_m;
    r_nxt.pin_d = r_r.pin_s;
    // hardware events, set regardless of enables
    if (timer0_overflow) r_nxt.tctrl[`IRC_TC_OVF0] = 1'b1;
    if (timer1_overflow) r_nxt.tctrl[`IRC_TC_OVF1] = 1'b1;
    // register writes; hardware set has priority over software clear below
    if (r_r.awdone & r_r.wdone & ~r_r.bvalid) begin
      wa = r_r.waddr;
      r_nxt.awdone = 1'b0;
      r_nxt.wdone = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = 2'b00;
      case (wa)
        `IRC_OFF_ENABLE: r_nxt.ien = wr_byte(r_r.ien, r_r.wdata, r_r.wstrb) & 8'h9f;
        `IRC_OFF_PRIORITY: r_nxt.ipr = wr_byte(r_r.ipr, r_r.wdata, r_r.wstrb) & 8'h1f;
        `IRC_OFF_TCTRL: r_nxt.tctrl = r_r.wdata[7:0] |
          ({timer1_overflow, 1'b0, timer0_overflow, 5'h00});
        `IRC_OFF_UCTRL: r_nxt.uctrl = r_r.wdata[7:0] | {6'h00, tx_done, rx_done};
        `IRC_OFF_PCTRL: r_nxt.pctrl = {r_r.pctrl[7:6], r_r.pctrl[5], r_r.wdata[4:0]};
        default: r_nxt.bresp = 2'b10;
      endcase
    end
    // pin events follow the write so a detected edge beats a software clear
    for (int i = 0; i < 2; i++) begin
      if (r_r.ien[`IRC_EN_EXT0 + 2 * i]) begin
        if (!r_r.tctrl[`IRC_TC_EDGE0 + 2 * i])
          r_nxt.tctrl[`IRC_TC_FLAG0 + 2 * i] = ~r_r.pin_s[i];
        else if (r_r.pin_d[i] & ~r_r.pin_s[i] & ~r_r.active[0] & ~r_r.active[1])
          r_nxt.tctrl[`IRC_TC_FLAG0 + 2 * i] = 1'b1;
      end
    end
    if (rx_done) r_nxt.uctrl[`IRC_UC_RX] = 1'b1;
    if (tx_done) r_nxt.uctrl[`IRC_UC_TX] = 1'b1;
    if (r_r.bvalid & s_axi_bready) r_nxt.bvalid = 1'b0;
    // reads
    if (rd_go) begin
      r_nxt.arready = 1'b0;
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp = 2'b00;
      case (rd_addr)
        `IRC_OFF_ENABLE: r_nxt.rdata = {24'h0, r_r.ien};
        `IRC_OFF_PRIORITY: r_nxt.rdata = {24'h0, r_r.ipr};
        `IRC_OFF_TCTRL: r_nxt.rdata = {24'h0, r_r.tctrl};
        `IRC_OFF_UCTRL: r_nxt.rdata = {24'h0, r_r.uctrl};
        `IRC_OFF_PCTRL: begin
          r_nxt.rdata = {24'h0, r_r.pctrl};
          r_nxt.pctrl[`IRC_PC_PWFLAG] = 1'b0;
        end
        `IRC_OFF_STATUS: r_nxt.rdata = {24'h0, r_r.vec[7:0]};
        default: begin
          r_nxt.rdata = 32'h0;
          r_nxt.rresp = 2'b10;
        end
      endcase
    end
    if (power_low) r_nxt.pctrl[`IRC_PC_PWFLAG] = 1'b1;
    if (r_r.rvalid & s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
      r_nxt.arready = 1'b1;
    end
    // pending sources with their enables
    pend[IRC_SRC_EXT0] = r_r.tctrl[`IRC_TC_FLAG0] & r_r.ien[`IRC_EN_EXT0];
    pend[IRC_SRC_TMR0] = r_r.tctrl[`IRC_TC_OVF0] & r_r.ien[`IRC_EN_TMR0];
    pend[IRC_SRC_EXT1] = r_r.tctrl[`IRC_TC_FLAG1] & r_r.ien[`IRC_EN_EXT1];
    pend[IRC_SRC_TMR1] = r_r.tctrl[`IRC_TC_OVF1] & r_r.ien[`IRC_EN_TMR1];
    pend[IRC_SRC_UART] = (r_r.uctrl[`IRC_UC_RX] | r_r.uctrl[`IRC_UC_TX]) &
                         r_r.ien[`IRC_EN_UART];
    pend[4:0] = pend[4:0] & {5{r_r.ien[`IRC_EN_GLOBAL]}};
    pend[IRC_SRC_PWR] = r_r.pctrl[`IRC_PC_PWFLAG] & r_r.pctrl[`IRC_PC_PWEN];
    hi = {1'b0, r_r.ipr[4:0]} & pend;
    // acknowledge sequence
    // a return is honoured in every state so a running resolve cannot swallow it
    if (return_from_irq) begin
      if (r_r.active[1]) r_nxt.active[1] = 1'b0;
      else r_nxt.active[0] = 1'b0;
      r_nxt.one_more = 1'b1;
    end else if (insn_boundary) begin
      r_nxt.one_more = 1'b0;
    end
    case (r_r.st)
      IRC_IDLE: begin
        if (insn_boundary & ~r_r.one_more & ~return_from_irq & (|pend)) begin
          r_nxt.latched = pend;
          r_nxt.st = IRC_IA1;
        end
      end
      IRC_IA1: begin
        // resolve: pfw, then any high, then low; nesting check
        if (r_r.latched[IRC_SRC_PWR]) begin
          s = IRC_SRC_PWR;
          blocked = 1'b0;
        end else if (|hi) begin
          s = pick(hi);
          blocked = r_r.active[1];
        end else begin
          s = pick(r_r.latched);
          blocked = r_r.active[1] | r_r.active[0];
        end
        if (~(|r_r.latched) | blocked | s == 3'h7) begin
          r_nxt.st = IRC_IDLE;
        end else begin
          r_nxt.src = s;
          r_nxt.hi_sel = (s == IRC_SRC_PWR) | ((hi >> s) != 6'h00 && hi[s]);
          r_nxt.vec = `IRC_VEC_BASE + ({13'h0, s} * `IRC_VEC_STEP);
          r_nxt.st = IRC_IA2;
        end
      end
      IRC_IA2: begin
        r_nxt.irq_req = 1'b1;
        r_nxt.st = IRC_IA3;
      end
      IRC_IA3: begin
        if (irq_ack) begin
          r_nxt.irq_req = 1'b0;
          clr = 6'h01 << r_r.src;
          if (r_r.src == IRC_SRC_EXT0 && r_r.tctrl[`IRC_TC_EDGE0])
            r_nxt.tctrl[`IRC_TC_FLAG0] = 1'b0;
          if (r_r.src == IRC_SRC_EXT1 && r_r.tctrl[`IRC_TC_EDGE1])
            r_nxt.tctrl[`IRC_TC_FLAG1] = 1'b0;
          if (clr[IRC_SRC_TMR0] & ~timer0_overflow) r_nxt.tctrl[`IRC_TC_OVF0] = 1'b0;
          if (clr[IRC_SRC_TMR1] & ~timer1_overflow) r_nxt.tctrl[`IRC_TC_OVF1] = 1'b0;
          if (clr[IRC_SRC_PWR] & ~power_low) r_nxt.pctrl[`IRC_PC_PWFLAG] = 1'b0;
          if (r_r.hi_sel) r_nxt.active[1] = 1'b1;
          else r_nxt.active[0] = 1'b1;
          r_nxt.st = IRC_IA4;
        end
      end
      IRC_IA4: r_nxt.st = IRC_IDLE;
      default: r_nxt.st = IRC_IDLE;
    endcase
    // ready lines are flops; they rise again on the edge where the response is taken
    r_nxt.awready = ~r_nxt.awdone & ~r_nxt.bvalid;
    r_nxt.wready = ~r_nxt.wdone & ~r_nxt.bvalid;
    if (!aresetn) begin
      r_nxt = '0;
      r_nxt.ien = `IRC_RST_BYTE;
      r_nxt.tctrl = `IRC_RST_BYTE;
      r_nxt.uctrl = `IRC_RST_BYTE;
      r_nxt.pin_m = 2'b11;
      r_nxt.pin_s = 2'b11;
      r_nxt.pin_d = 2'b11;
      r_nxt.arready = 1'b1;
      r_nxt.awready = 1'b1;
      r_nxt.wready = 1'b1;
      r_nxt.st = IRC_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    r_r <= r_nxt;
  end

  assign s_axi_awready = r_r.awready;
  assign s_axi_wready = r_r.wready;
  assign s_axi_bvalid = r_r.bvalid;
  assign s_axi_bresp = r_r.bresp;
  assign s_axi_arready = r_r.arready;
  assign s_axi_rvalid = r_r.rvalid;
  assign s_axi_rdata = r_r.rdata;
  assign s_axi_rresp = r_r.rresp;
  assign irq_request = r_r.irq_req;
  assign irq_vector = r_r.vec;
  // synchronised pins drive port bits 2 and 3 whether or not their source is enabled
  assign port3_irq_pins = {4'h0, r_r.pin_s, 2'b00};
  assign timer0_run = r_r.tctrl[`IRC_TC_TRUN0];
  assign timer1_run = r_r.tctrl[`IRC_TC_TRUN1];
  assign uart_rx_enable = r_r.uctrl[`IRC_UC_REN];

  ack_four_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_r.st == IRC_IA1 && r_nxt.st == IRC_IA2) |=> ##1 irq_request)
    else $error("request not raised two cycles after resolve");
  vec_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_request |-> irq_vector == 16'h0003 + 16'(r_r.src) * 16'h0008)
    else $error("vector does not match source");
  glob_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_r.st == IRC_IA1 && !r_r.ien[7] && r_nxt.st == IRC_IA2) |-> r_nxt.src == IRC_SRC_PWR)
    else $error("non-power source taken with global enable off");
  reset_ea_a: assert property (@(posedge aclk)
    !aresetn |=> !r_r.ien[7])
    else $error("global enable survives reset");
  boundary_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_r.st == IRC_IDLE && r_nxt.st == IRC_IA1) |-> insn_boundary)
    else $error("sequence started off instruction boundary");
  tmr_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    timer0_overflow |=> r_r.tctrl[5])
    else $error("timer0 overflow flag not set");
  uart_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_r.st == IRC_IA3 && irq_ack && r_r.src == IRC_SRC_UART && r_r.uctrl[0] &&
     !(r_r.bvalid == 1'b0 && r_r.awdone && r_r.wdone)) |=> r_r.uctrl[0])
    else $error("serial flag cleared by service");
  pwr_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    power_low |=> r_r.pctrl[5])
    else $error("power warning flag not set");
  req_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_request && irq_ack) |=> !irq_request ##1 r_r.st == IRC_IDLE)
    else $error("request not dropped after acknowledge");
  lvl_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_r.ien[`IRC_EN_EXT1] && !r_r.tctrl[`IRC_TC_EDGE1]) |=>
    r_r.tctrl[`IRC_TC_FLAG1] == !$past(r_r.pin_s[1]))
    else $error("level flag does not follow pin");
  edge_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_r.tctrl[`IRC_TC_EDGE0] && r_r.tctrl[`IRC_TC_FLAG0] && !(r_r.st == IRC_IA3 && irq_ack) &&
     !(r_r.awdone && r_r.wdone && !r_r.bvalid)) |=> r_r.tctrl[`IRC_TC_FLAG0])
    else $error("edge flag lost before service");
  rti_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (return_from_irq && r_r.active == 2'b01 && !(r_r.st == IRC_IA3 && irq_ack)) |=> r_r.active == 2'b00)
    else $error("return did not clear in-service level");
  pw_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr == `IRC_OFF_PCTRL && !power_low) |=> !r_r.pctrl[`IRC_PC_PWFLAG])
    else $error("power warning flag not cleared by read");
  ovf_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (r_r.st == IRC_IA3 && irq_ack && r_r.src == IRC_SRC_TMR0 && !timer0_overflow &&
     !(r_r.awdone && r_r.wdone && !r_r.bvalid)) |=> !r_r.tctrl[`IRC_TC_OVF0])
    else $error("timer0 flag kept after service");
  skip_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (return_from_irq && r_r.st == IRC_IDLE) |=> (r_r.st == IRC_IDLE && r_r.one_more))
    else $error("no instruction allowed after return");
  cv_take_c: cover property (@(posedge aclk) disable iff (!aresetn) irq_request && irq_ack);
  cv_pwr_c: cover property (@(posedge aclk) disable iff (!aresetn)
    irq_request && r_r.src == IRC_SRC_PWR);
  cv_nest_c: cover property (@(posedge aclk) disable iff (!aresetn) r_r.active == 2'b11);
  cv_edge_c: cover property (@(posedge aclk) disable iff (!aresetn)
    r_r.tctrl[`IRC_TC_EDGE0] && r_r.tctrl[`IRC_TC_FLAG0]);
  cv_slow_c: cover property (@(posedge aclk) disable iff (!aresetn)
    irq_request && !irq_ack ##1 irq_request && !irq_ack);
endmodule

// [sim/irc_core_model.sv]
// core sequencer model that takes vector calls and returns
`timescale 1ns/1ns
module irc_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic slow,
  input wire logic do_ret,
  output logic insn_boundary,
  output logic irq_ack,
  output logic return_from_irq,
  output logic [7:0] ack_cnt,
  output logic [15:0] last_vec
);
  logic [1:0] cyc_r;
  logic [1:0] wait_r;
  // every instruction lasts four machine cycles
  assign insn_boundary = (cyc_r == 2'h3);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_r <= 2'h0;
      wait_r <= 2'h0;
      irq_ack <= 1'b0;
      return_from_irq <= 1'b0;
      ack_cnt <= 8'h00;
      last_vec <= 16'h0000;
    end else begin
      cyc_r <= cyc_r + 2'h1;
      irq_ack <= 1'b0;
      return_from_irq <= do_ret;
      // slow mode leaves the request standing three more cycles
      if (irq_request && !irq_ack) begin
        if (!slow || wait_r == 2'h3) begin
          irq_ack <= 1'b1;
          ack_cnt <= ack_cnt + 8'h01;
          last_vec <= irq_vector;
          wait_r <= 2'h0;
        end else begin
          wait_r <= wait_r + 2'h1;
        end
      end
    end
  end
endmodule

// [sim/tb_interrupt_request_control.sv]
// self-checking bench for the interrupt request block
`timescale 1ns/1ns
module tb_interrupt_request_control;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] aw_a = 8'h00;
  logic aw_v = 1'b0;
  logic [31:0] w_d = 32'h0;
  logic w_v = 1'b0;
  logic [7:0] ar_a = 8'h00;
  logic ar_v = 1'b0;
  logic [1:0] pin = 2'b11;
  logic [3:0] ev = 4'h0;
  logic pwl = 1'b0;
  logic slow = 1'b0;
  logic do_ret = 1'b0;
  logic [1:0] wr_resp = 2'b00;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, bnd, ack, rti, req, t0run, t1run, rxen;
  logic [1:0] b_rs, r_rs;
  logic [31:0] r_d;
  logic [15:0] vec, last_vec;
  logic [7:0] p3, ack_cnt, n_svc;
  int errors = 0;
  int total_checks = 0;
  always #20 aclk = ~aclk;
  irc_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_rs), .s_axi_bvalid(b_v),
    .s_axi_bready(1'b1), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v),
    .s_axi_rready(1'b1), .ext_irq0_pin(pin[0]), .ext_irq1_pin(pin[1]),
    .timer0_overflow(ev[0]), .timer1_overflow(ev[1]), .rx_done(ev[2]), .tx_done(ev[3]),
    .power_low(pwl), .insn_boundary(bnd), .irq_ack(ack), .return_from_irq(rti),
    .irq_request(req), .irq_vector(vec), .port3_irq_pins(p3), .timer0_run(t0run),
    .timer1_run(t1run), .uart_rx_enable(rxen));
  irc_core_model core (.aclk(aclk), .aresetn(aresetn), .irq_request(req), .irq_vector(vec),
    .slow(slow), .do_ret(do_ret), .insn_boundary(bnd), .irq_ack(ack),
    .return_from_irq(rti), .ack_cnt(ack_cnt), .last_vec(last_vec));
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // each handshake is judged at the rising edge where valid and ready meet
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic b_t;
    int n;
    n = 0;
    b_t = 1'b0;
    aw_a <= a;
    w_d <= {24'h0, d};
    aw_v <= 1'b1;
    w_v <= 1'b1;
    while (!b_t && n < 100) begin
      @(posedge aclk);
      if (aw_v & aw_rdy) aw_v <= 1'b0;
      if (w_v & w_rdy) w_v <= 1'b0;
      b_t = b_v;
      if (b_t) wr_resp = b_rs;
      n++;
    end
    if (!b_t) chk8(8'h00, 8'h01);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] rs);
    logic r_t;
    logic [7:0] d;
    logic [1:0] s;
    int n;
    n = 0;
    r_t = 1'b0;
    d = 8'h00;
    s = 2'b00;
    ar_a <= a;
    ar_v <= 1'b1;
    while (!r_t && n < 100) begin
      @(posedge aclk);
      if (ar_v & ar_rdy) ar_v <= 1'b0;
      r_t = r_v;
      d = r_d[7:0];
      s = r_rs;
      n++;
    end
    if (!r_t) chk8(8'h00, 8'h01);
    chk8(d, exp);
    chk8({6'h0, s}, {6'h0, rs});
  endtask
  task automatic pulse(input logic [3:0] m, input logic p);
    ev <= m;
    pwl <= p;
    @(posedge aclk);
    ev <= 4'h0;
    pwl <= 1'b0;
  endtask
  task automatic svc(input logic [15:0] exp);
    int n;
    n = 0;
    while (ack_cnt === n_svc && n < 200) begin
      @(posedge aclk);
      n++;
    end
    chk8(ack_cnt, n_svc + 8'h01);
    n_svc = n_svc + 8'h01;
    chk16(last_vec, exp);
  endtask
  task automatic quiet(input int c);
    logic seen;
    seen = 1'b0;
    repeat (c) begin
      @(posedge aclk);
      seen = seen | (ack_cnt !== n_svc);
    end
    chk8({7'h0, seen}, 8'h00);
  endtask
  task automatic ret();
    do_ret <= 1'b1;
    @(posedge aclk);
    do_ret <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic pin_low(input logic [1:0] p);
    pin <= p;
    repeat (3) @(posedge aclk);
    pin <= 2'b11;
    repeat (4) @(posedge aclk);
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    n_svc = 8'h00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) rd(8'(i * 4), 8'h00, 2'b00);
    chk8({5'h0, t0run, t1run, rxen}, 8'h00);
    rd(8'h18, 8'h00, 2'b10);
    wr(8'h18, 8'h00);
    chk8({6'h0, wr_resp}, 8'h02);
    wr(8'h08, 8'h50);
    chk8({6'h0, wr_resp}, 8'h00);
    wr(8'h0c, 8'h10);
    chk8({5'h0, t0run, t1run, rxen}, 8'h07);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h00);
    pulse(4'h1, 1'b0);
    quiet(12);
    rd(8'h08, 8'h20, 2'b00);
    wr(8'h00, 8'h02);
    quiet(12);
    wr(8'h00, 8'h82);
    svc(16'h000b);
    rd(8'h08, 8'h00, 2'b00);
    ret();
    wr(8'h00, 8'h00);
    pulse(4'h3, 1'b0);
    wr(8'h00, 8'h8a);
    svc(16'h000b);
    ret();
    svc(16'h001b);
    ret();
    pulse(4'h1, 1'b0);
    svc(16'h000b);
    pulse(4'h2, 1'b0);
    quiet(20);
    ret();
    svc(16'h001b);
    ret();
    wr(8'h04, 8'h08);
    pulse(4'h1, 1'b0);
    svc(16'h000b);
    pulse(4'h2, 1'b0);
    svc(16'h001b);
    ret();
    ret();
    wr(8'h04, 8'h00);
    // a slow core keeps the request standing
    slow <= 1'b1;
    wr(8'h00, 8'h90);
    pulse(4'hc, 1'b0);
    svc(16'h0023);
    rd(8'h0c, 8'h03, 2'b00);
    wr(8'h0c, 8'h00);
    ret();
    slow <= 1'b0;
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h08);
    pulse(4'h0, 1'b1);
    svc(16'h002b);
    ret();
    wr(8'h10, 8'h00);
    pulse(4'h0, 1'b1);
    rd(8'h10, 8'h20, 2'b00);
    rd(8'h10, 8'h00, 2'b00);
    wr(8'h08, 8'h01);
    wr(8'h00, 8'h01);
    pin_low(2'b10);
    chk8(p3 & 8'h0c, 8'h0c);
    rd(8'h08, 8'h03, 2'b00);
    wr(8'h00, 8'h81);
    svc(16'h0003);
    rd(8'h08, 8'h01, 2'b00);
    pin_low(2'b10);
    ret();
    quiet(20);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h04);
    pin <= 2'b01;
    repeat (4) @(posedge aclk);
    rd(8'h08, 8'h08, 2'b00);
    pin <= 2'b11;
    repeat (4) @(posedge aclk);
    rd(8'h08, 8'h00, 2'b00);
    pin <= 2'b01;
    wr(8'h00, 8'h84);
    svc(16'h0013);
    ret();
    svc(16'h0013);
    pin <= 2'b11;
    wr(8'h00, 8'h00);
    ret();
    print_verdict();
  end
  // the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    print_verdict();
  end
endmodule
